// file: src/dmr_cfg.svh
// Constants for the mode register programming block
`ifndef DMR_CFG_SVH
`define DMR_CFG_SVH
`define DMR_CLK_PS 8000
`define DMR_GAP_NS 10
`define DMR_GAP_CYC ((`DMR_GAP_NS * 1000 + `DMR_CLK_PS - 1) / `DMR_CLK_PS)
`define DMR_OFS_CTRL 8'h00
`define DMR_OFS_MODE 8'h04
`define DMR_OFS_EXT 8'h08
`define DMR_OFS_STAT 8'h0C
`define DMR_CTRL_RST 1'b1
`define DMR_BIT_ERRRSV 8
`define DMR_BIT_ERRGAP 9
`define DMR_BL_LSB 0
`define DMR_BT_BIT 3
`define DMR_LAT_LSB 4
`define DMR_TM_LSB 7
`define DMR_EXT_DLL 0
`define DMR_EXT_WEAK 1
`define DMR_LAT_2 3'h2
`define DMR_LAT_3 3'h3
`define DMR_LAT_25 3'h6
`define DMR_TM_NORM 2'h0
`define DMR_TM_DLLRST 2'h2
`endif

// file: src/dmr_pkg.sv
// Types shared by the mode register programming block
package dmr_pkg;
  typedef logic [7:0] dmr_addr_t;
  typedef logic [31:0] dmr_word_t;
  typedef logic [12:0] dmr_mreg_t;
  typedef enum logic [2:0] {
    CMD_DESEL, CMD_NOP, CMD_LOAD, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR,
    CMD_OTHER
  } dmr_cmd_t;
  typedef enum logic {PD_AWAKE, PD_ACTIVE} dmr_pd_t;
endpackage : dmr_pkg

// file: src/dmr_burst_if.sv
// Link between command decode and the burst address generator
`timescale 1ns/100ps
`default_nettype none
interface dmr_burst_if;
  logic ce;
  logic start;
  logic [2:0] startCol;
  logic [2:0] lenCode;
  logic ilv;
  logic [2:0] col;
  logic valid;
  modport ctl(output ce, start, startCol, lenCode, ilv,
    input col, valid);
  modport gen(input ce, start, startCol, lenCode, ilv,
    output col, valid);
endinterface : dmr_burst_if
`default_nettype wire

// file: src/dmr_burst_gen.sv
// Burst column order generator, sequential or interleaved
`timescale 1ns/100ps
`default_nettype none
module dmr_burst_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link to decoder
  dmr_burst_if.gen bif
);
  import dmr_pkg::*;
  logic [2:0] base_ff;
  logic [2:0] mask_ff;
  logic [2:0] beat_ff;
  logic ilv_ff;
  logic [2:0] nxt_beat;
  logic [2:0] nxt_col;
  logic [2:0] mask;
  logic last;

  // Block mask from length code, reserved codes give one beat
  always_comb begin
    case (bif.lenCode)
      3'h1: mask = 3'h1;
      3'h2: mask = 3'h3;
      3'h3: mask = 3'h7;
      default: mask = 3'h0;
    endcase
  end

  // Next column inside the aligned block
  assign nxt_beat = 3'(beat_ff + 3'h1);
  assign last = (beat_ff == mask_ff);
  always_comb begin
    if (ilv_ff) begin
      nxt_col = (base_ff & ~mask_ff)
        | ((base_ff ^ nxt_beat) & mask_ff);
    end else begin
      nxt_col = (base_ff & ~mask_ff)
        | (3'(base_ff + nxt_beat) & mask_ff);
    end
  end

  // Beat sequencing, a new start cuts the old burst
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_ff <= 3'h0;
      mask_ff <= 3'h0;
      beat_ff <= 3'h0;
      ilv_ff <= 1'b0;
      bif.col <= 3'h0;
      bif.valid <= 1'b0;
    end else if (bif.ce) begin
      if (bif.start) begin
        base_ff <= bif.startCol;
        mask_ff <= mask;
        ilv_ff <= bif.ilv;
        beat_ff <= 3'h0;
        bif.col <= bif.startCol;
        bif.valid <= 1'b1;
      end else if (bif.valid) begin
        if (last) begin
          bif.valid <= 1'b0;
        end else begin
          beat_ff <= nxt_beat;
          bif.col <= nxt_col;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !bif.ce);
  a_burst_first: assert property (bif.start |=>
    bif.col == $past(bif.startCol))
    else $error("burst does not open at start column");
  a_burst_end: assert property (bif.valid && last
    && !bif.start && $past(bif.ce) |=> !bif.valid)
    else $error("burst runs past its length");
  a_ilv_pair: assert property (bif.start && bif.ilv
    && bif.lenCode == 3'h1 ##1 !bif.start
    |=> bif.col == ($past(bif.col) ^ 3'h1))
    else $error("interleaved pair order wrong");
  c_ilv8: cover property (bif.start && bif.ilv && bif.lenCode == 3'h3);
endmodule : dmr_burst_gen
`default_nettype wire

// file: src/dmr_mode_ctl.sv
// Command decode, mode registers and APB access for the DRAM die
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dmr_cfg.svh"
module dmr_mode_ctl (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Command pins from the memory controller
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic bank_addr_bit0,
  input wire logic bank_addr_bit1,
  input wire logic [12:0] addr,
  input wire logic cke,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire dmr_pkg::dmr_addr_t paddr,
  input wire dmr_pkg::dmr_word_t pwdata,
  output var dmr_pkg::dmr_word_t prdata,
  output logic pready,
  output logic pslverr,
  // Burst and write lanes
  output logic [9:0] burstCol,
  output logic burstValid,
  output logic burstWrite,
  output logic [1:0] byteWrEn,
  // Mode state
  output logic dllEnable,
  output logic weakDrive,
  output logic dllReset,
  output logic [3:0] latHalf,
  output logic powerDown,
  output logic modeErr
);
  import dmr_pkg::*;
  localparam int PIN_W = 22;
  localparam logic [1:0] GAP_LD = 2'(`DMR_GAP_CYC - 1);

  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] sync1_ff;
  logic [PIN_W-1:0] sync2_ff;
  logic sCs, sRas, sCas, sWe, sBa0, sCke, sLm, sUm;
  logic [12:0] sAddr;
  logic ckePrev_ff;
  dmr_cmd_t cmd;
  logic cmdOk;
  logic loadMode, loadExt, isNop;
  dmr_mreg_t mode_ff;
  dmr_mreg_t ext_ff;
  logic modeValid_ff, extValid_ff;
  logic [3:0] bankAct_ff;
  dmr_pd_t pd_ff;
  logic [1:0] gap_ff;
  logic errRsv_ff, errGap_ff, setRsv, setGap, clrRsv, clrGap;
  logic rsvCode, ctrlEn_ff;
  logic [6:0] colHi_ff;
  logic wrBurst_ff;
  logic apbSetup, apbWr, hit;
  dmr_word_t rdMux;
  dmr_burst_if bif();

  // Pins pass two flops before any decode
  assign pinRaw = {csN, rasN, casN, weN, bank_addr_bit1,
    bank_addr_bit0, addr, cke, lower_byte_mask, upper_byte_mask};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= {PIN_W{1'b1}};
      sync2_ff <= {PIN_W{1'b1}};
    end else if (ce) begin
      sync1_ff <= pinRaw;
      sync2_ff <= sync1_ff;
    end
  end
  assign sCs = sync2_ff[21];
  assign sRas = sync2_ff[20];
  assign sCas = sync2_ff[19];
  assign sWe = sync2_ff[18];
  assign sBa0 = sync2_ff[16];
  assign sAddr = sync2_ff[15:3];
  assign sCke = sync2_ff[2];
  assign sLm = sync2_ff[1];
  assign sUm = sync2_ff[0];

  // Clock enable one clock earlier
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ckePrev_ff <= 1'b0;
    end else if (ce) begin
      ckePrev_ff <= sCke;
    end
  end

  // Command decode from the four strobes
  always_comb begin
    case ({sCs, sRas, sCas, sWe})
      4'h0: cmd = CMD_LOAD;
      4'h3: cmd = CMD_ACT;
      4'h2: cmd = CMD_PRE;
      4'h5: cmd = CMD_RD;
      4'h4: cmd = CMD_WR;
      4'h7: cmd = CMD_NOP;
      default: cmd = sCs ? CMD_DESEL : CMD_OTHER;
    endcase
  end
  assign isNop = (cmd == CMD_NOP) || (cmd == CMD_DESEL);
  assign cmdOk = ckePrev_ff && sCke && ctrlEn_ff
    && (pd_ff == PD_AWAKE);
  assign loadMode = cmdOk && (cmd == CMD_LOAD) && !sBa0;
  assign loadExt = cmdOk && (cmd == CMD_LOAD) && sBa0;

  // Mode and extended mode registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= 13'h0000;
      ext_ff <= 13'h0000;
      modeValid_ff <= 1'b0;
      extValid_ff <= 1'b0;
    end else if (ce) begin
      if (loadMode) begin
        mode_ff <= sAddr;
        modeValid_ff <= 1'b1;
      end
      if (loadExt) begin
        ext_ff <= sAddr;
        extValid_ff <= 1'b1;
      end
    end
  end

  // Decoded mode outputs, held until the next load
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latHalf <= 4'h0;
      dllReset <= 1'b0;
      dllEnable <= 1'b0;
      weakDrive <= 1'b0;
    end else if (ce) begin
      if (loadMode) begin
        case (sAddr[`DMR_LAT_LSB +: 3])
          `DMR_LAT_2: latHalf <= 4'h4;
          `DMR_LAT_3: latHalf <= 4'h6;
          `DMR_LAT_25: latHalf <= 4'h5;
          default: latHalf <= 4'h0;
        endcase
        dllReset <= (sAddr[`DMR_TM_LSB +: 2] == `DMR_TM_DLLRST);
      end
      if (loadExt) begin
        dllEnable <= sAddr[`DMR_EXT_DLL];
        weakDrive <= sAddr[`DMR_EXT_WEAK];
      end
    end
  end

  // Reserved codes in a base register load
  always_comb begin
    rsvCode = 1'b0;
    if (sAddr[2:0] == 3'h0 || sAddr[2] == 1'b1) begin
      rsvCode = 1'b1;
    end
    if (sAddr[6:4] != `DMR_LAT_2 && sAddr[6:4] != `DMR_LAT_3
        && sAddr[6:4] != `DMR_LAT_25) begin
      rsvCode = 1'b1;
    end
    if (sAddr[8:7] != `DMR_TM_NORM && sAddr[8:7] != `DMR_TM_DLLRST) begin
      rsvCode = 1'b1;
    end
  end
  assign setRsv = loadMode && rsvCode;
  assign setGap = cmdOk && !isNop && (gap_ff != 2'h0);

  // Load gap counter after each register load
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= 2'h0;
    end else if (ce) begin
      if (loadMode || loadExt) begin
        gap_ff <= GAP_LD;
      end else if (gap_ff != 2'h0) begin
        gap_ff <= 2'(gap_ff - 2'h1);
      end
    end
  end

  // Sticky errors, a new event wins over the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      errRsv_ff <= 1'b0;
      errGap_ff <= 1'b0;
      modeErr <= 1'b0;
    end else if (ce) begin
      errRsv_ff <= setRsv || (errRsv_ff && !clrRsv);
      errGap_ff <= setGap || (errGap_ff && !clrGap);
      modeErr <= setRsv || setGap || ((errRsv_ff && !clrRsv)
        || (errGap_ff && !clrGap));
    end
  end

  // Bank open state, one flop per bank
  for (genvar b = 0; b < 4; b++) begin : gBank
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        bankAct_ff[b] <= 1'b0;
      end else if (ce && cmdOk) begin
        if (cmd == CMD_ACT && sync2_ff[17:16] == 2'(b)) begin
          bankAct_ff[b] <= 1'b1;
        end else if (cmd == CMD_PRE
            && (sAddr[10] || sync2_ff[17:16] == 2'(b))) begin
          bankAct_ff[b] <= 1'b0;
        end
      end
    end
  end

  // Active power-down entry and exit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_ff <= PD_AWAKE;
    end else if (ce) begin
      case (pd_ff)
        PD_AWAKE: begin
          if (ckePrev_ff && !sCke && (|bankAct_ff)) begin
            pd_ff <= PD_ACTIVE;
          end
        end
        PD_ACTIVE: begin
          if (!ckePrev_ff && sCke && isNop) begin
            pd_ff <= PD_AWAKE;
          end
        end
        default: pd_ff <= PD_AWAKE;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerDown <= 1'b0;
    end else if (ce) begin
      powerDown <= (pd_ff == PD_ACTIVE);
    end
  end

  // Burst start on column command while any bank is open
  assign bif.ce = ce;
  assign bif.start = cmdOk && (cmd == CMD_RD || cmd == CMD_WR)
    && (|bankAct_ff);
  assign bif.startCol = sAddr[2:0];
  assign bif.lenCode = mode_ff[`DMR_BL_LSB +: 3];
  assign bif.ilv = mode_ff[`DMR_BT_BIT];
  dmr_burst_gen uGen (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bif(bif)
  );

  // Upper column bits and burst direction
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      colHi_ff <= 7'h00;
      wrBurst_ff <= 1'b0;
    end else if (ce && bif.start) begin
      colHi_ff <= sAddr[9:3];
      wrBurst_ff <= (cmd == CMD_WR);
    end
  end

  // Registered burst outputs and byte lane enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burstCol <= 10'h000;
      burstValid <= 1'b0;
      burstWrite <= 1'b0;
      byteWrEn <= 2'h0;
    end else if (ce) begin
      burstCol <= {colHi_ff, bif.col};
      burstValid <= bif.valid;
      burstWrite <= bif.valid && wrBurst_ff;
      if (bif.valid && wrBurst_ff && (|bankAct_ff)) begin
        byteWrEn <= {!sUm, !sLm};
      end else begin
        byteWrEn <= 2'h0;
      end
    end
  end

  // APB decode, answer ready in the access phase
  assign apbSetup = psel && !penable;
  assign apbWr = psel && penable && pready && pwrite;
  assign hit = (paddr == `DMR_OFS_CTRL) || (paddr == `DMR_OFS_MODE)
    || (paddr == `DMR_OFS_EXT) || (paddr == `DMR_OFS_STAT);
  assign clrRsv = apbWr && !pslverr && (paddr == `DMR_OFS_STAT)
    && pwdata[`DMR_BIT_ERRRSV];
  assign clrGap = apbWr && !pslverr && (paddr == `DMR_OFS_STAT)
    && pwdata[`DMR_BIT_ERRGAP];
  always_comb begin
    case (paddr)
      `DMR_OFS_CTRL: rdMux = {31'h0, ctrlEn_ff};
      `DMR_OFS_MODE: rdMux = {19'h0, mode_ff};
      `DMR_OFS_EXT: rdMux = {19'h0, ext_ff};
      `DMR_OFS_STAT: rdMux = {22'h0, errGap_ff, errRsv_ff, 1'b0,
        extValid_ff, modeValid_ff, (pd_ff == PD_ACTIVE), bankAct_ff};
      default: rdMux = 32'h0;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= apbSetup;
      pslverr <= apbSetup && !hit;
      prdata <= (apbSetup && !pwrite) ? rdMux : 32'h0;
    end
  end

  // Control register write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlEn_ff <= `DMR_CTRL_RST;
    end else if (ce && apbWr && paddr == `DMR_OFS_CTRL) begin
      ctrlEn_ff <= pwdata[0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !ce);
  a_mode_store: assert property (loadMode |=>
    mode_ff == $past(sAddr))
    else $error("base register missed its load");
  a_ext_select: assert property (loadExt |=>
    ext_ff == $past(sAddr) && $stable(mode_ff))
    else $error("extended load went to the wrong register");
  a_mode_hold: assert property (!loadMode |=> $stable(mode_ff))
    else $error("base register changed without a load");
  a_cke_prev: assert property ($past(rst_n) && $past(ce)
    |-> ckePrev_ff == $past(sCke))
    else $error("previous clock enable not one clock old");
  a_pd_exit: assert property (pd_ff == PD_ACTIVE && !ckePrev_ff
    && sCke && isNop |=> pd_ff == PD_AWAKE ##1 !powerDown)
    else $error("power-down exit not taken");
  a_lane_mask: assert property (bif.valid && wrBurst_ff
    && sLm |=> !byteWrEn[0])
    else $error("masked lower byte was written");
  a_lat_half: assert property (loadMode && sAddr[6:4] == 3'h6
    |=> latHalf == 4'h5)
    else $error("latency 2.5 not decoded");
  a_rsv_flag: assert property (loadMode && (sAddr[2:0] == 3'h0
    || sAddr[6:4] == 3'h7) |=> errRsv_ff && modeErr)
    else $error("reserved code not flagged");
  c_ext_load: cover property (loadExt ##[2:4] loadMode);
  c_pd_cycle: cover property (pd_ff == PD_ACTIVE ##[1:20] pd_ff == PD_AWAKE);
endmodule : dmr_mode_ctl
`default_nettype wire

// file: tb/dmr_ctl_model.sv
// Memory controller model that drives the command pins
`timescale 1ns/100ps
`default_nettype none
module dmr_ctl_model (
  // Clock
  input wire logic core_clk,
  // Command pins
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic bank_addr_bit0,
  output logic bank_addr_bit1,
  output logic [12:0] addr,
  output logic cke,
  // Write lane masks
  output logic lower_byte_mask,
  output logic upper_byte_mask
);
  // Idle: no-op, clock enable already high before any load
  initial begin
    {csN, rasN, casN, weN} = 4'h7;
    {bank_addr_bit0, bank_addr_bit1, addr} = '0;
    cke = 1'b1;
    {upper_byte_mask, lower_byte_mask} = 2'h0;
  end

  // One command, then no-ops for the spacing asked for
  task automatic issue(input logic [3:0] c, input logic ba,
    input logic [12:0] a, input int gap);
    {csN, rasN, casN, weN} <= c;
    bank_addr_bit0 <= ba;
    bank_addr_bit1 <= 1'b0;
    addr <= a;
    @(posedge core_clk);
    if (gap > 0) begin
      {csN, rasN, casN, weN} <= 4'h7;
      addr <= ~a; // Released bus shows the inverse
    end
    repeat (gap) @(posedge core_clk);
  endtask : issue

  // Enter power-down with deselect, leave it with a no-op
  task automatic doze(input logic on);
    cke <= !on;
    {csN, rasN, casN, weN} <= on ? 4'hF : 4'h7;
  endtask : doze

  // Masks held for the following write burst
  task automatic mask(input logic [1:0] m);
    {upper_byte_mask, lower_byte_mask} <= m;
  endtask : mask
endmodule : dmr_ctl_model
`default_nettype wire

// file: tb/dmr_mode_ctl_test.sv
// Self-checking bench for the mode register block
`timescale 1ns/100ps
`default_nettype none
module dmr_mode_ctl_test;
  import dmr_pkg::*;
  // Command codes as cs, ras, cas, we
  localparam logic [3:0] C_LOAD = 4'h0;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_WR = 4'h4;
  localparam logic [3:0] C_RD = 4'h5;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  dmr_addr_t paddr;
  dmr_word_t pwdata, prdata;
  logic burstValid, burstWrite, dllEnable, weakDrive, dllReset;
  logic powerDown, modeErr, csN, rasN, casN, weN, cke, ce;
  logic bank_addr_bit0, bank_addr_bit1, lower_byte_mask, upper_byte_mask;
  logic [12:0] addr;
  logic [9:0] burstCol;
  logic [1:0] byteWrEn;
  logic [3:0] latHalf;
  int fails, n_compared;
  logic [32:0] rdQ[$];
  logic [12:0] beatQ[$];
  logic [32:0] rdExp;
  logic [12:0] beatExp;
  logic [31:0] rnd;
  logic [2:0] latCode[3] = '{3'h2, 3'h3, 3'h6};
  logic [3:0] latExp[3] = '{4'h4, 4'h6, 4'h5};

  dmr_ctl_model ctl (.core_clk, .csN, .rasN, .casN, .weN, .bank_addr_bit0,
    .bank_addr_bit1, .addr, .cke, .lower_byte_mask, .upper_byte_mask);
  dmr_mode_ctl DUT (.core_clk, .rst_n, .ce, .csN, .rasN, .casN, .weN,
    .bank_addr_bit0, .bank_addr_bit1, .addr, .cke, .lower_byte_mask,
    .upper_byte_mask, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .burstCol, .burstValid, .burstWrite, .byteWrEn,
    .dllEnable, .weakDrive, .dllReset, .latHalf, .powerDown, .modeErr);

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Compare and count
  task automatic check(input string what, input logic [32:0] seen,
    input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic report_and_stop;
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // One APB transfer; a read notes its expected answer
  task automatic apb(input logic wr, input dmr_addr_t a, input dmr_word_t d,
    input logic [32:0] exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) rdQ.push_back(exp);
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // Notes the column order of one burst
  task automatic push(input logic [9:0] s, input int len, input int t,
    input logic w, input logic [1:0] en);
    logic [2:0] m, lo;
    m = 3'(len - 1);
    for (int i = 0; i < len; i++) begin
      lo = t ? s[2:0] ^ 3'(i) : s[2:0] + 3'(i);
      beatQ.push_back({w, en, s[9:3], (s[2:0] & ~m) | (lo & m)});
    end
  endtask : push

  // Watcher: each read answer or burst beat takes the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      rdExp = rdQ.size() > 0 ? rdQ.pop_front() : 'x;
      if (rdExp[32] === 1'b1) check("pslverr", 33'(pslverr), 33'h1);
      else check("prdata", {pslverr, prdata}, rdExp);
    end
    if (burstValid === 1'b1) begin
      beatExp = beatQ.size() > 0 ? beatQ.pop_front() : 'x;
      check("beat", 33'({burstWrite, burstWrite ? byteWrEn : 2'h0,
        burstCol}), 33'(beatExp));
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    ce = 1'b1;
    fails = 0;
    n_compared = 0;
    rnd = 32'hD700_6320;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Reset values and an unmapped place
    apb(1'b0, 8'h00, '0, 33'h1);
    apb(1'b0, 8'h0C, '0, 33'h0);
    apb(1'b0, 8'h14, '0, {1'b1, 32'h0});
    // Power-up order: precharge, DLL on and weak drive, DLL reset
    ctl.issue(C_PRE, 1'b0, 13'h0400, 4);
    ctl.issue(C_LOAD, 1'b1, 13'h0003, 4);
    check("dllEnable", 33'(dllEnable), 33'h1);
    check("weakDrive", 33'(weakDrive), 33'h1);
    apb(1'b0, 8'h08, '0, 33'h3);
    ctl.issue(C_LOAD, 1'b0, 13'h0132, 4);
    check("dllReset", 33'(dllReset), 33'h1);
    check("latHalf", 33'(latHalf), 33'h6);
    // Read-only write and disabled decode leave the register alone
    apb(1'b1, 8'h04, '0, '0);
    apb(1'b1, 8'h00, '0, '0);
    ctl.issue(C_LOAD, 1'b0, 13'h0062, 4);
    apb(1'b0, 8'h04, '0, 33'h132);
    apb(1'b1, 8'h00, 32'h1, '0);
    // Each latency code with normal test bits
    for (int k = 0; k < 3; k++) begin
      ctl.issue(C_LOAD, 1'b0, {6'h0, latCode[k], 4'h2}, 4);
      check("latHalf", 33'(latHalf), 33'(latExp[k]));
      check("dllReset", 33'(dllReset), 33'h0);
    end
    // Clock enable low freezes the pins, a load meanwhile is lost
    ce <= 1'b0;
    ctl.issue(C_LOAD, 1'b0, 13'h0022, 4);
    ce <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("latHalf", 33'(latHalf), 33'(latExp[2]));
    apb(1'b0, 8'h04, '0, 33'h062);
    // Reserved latency sets the sticky error, writing one clears it
    ctl.issue(C_LOAD, 1'b0, 13'h0072, 4);
    check("modeErr", 33'(modeErr), 33'h1);
    check("latHalf", 33'(latHalf), 33'h0);
    apb(1'b0, 8'h0C, '0, 33'h160);
    apb(1'b1, 8'h0C, 32'h100, '0);
    // A command straight after a load breaks the spacing
    ctl.issue(C_LOAD, 1'b0, 13'h0022, 0);
    ctl.issue(C_ACT, 1'b0, 13'h0000, 4);
    apb(1'b0, 8'h0C, '0, 33'h261);
    apb(1'b1, 8'h0C, 32'h200, '0);
    repeat (2) @(posedge core_clk);
    check("modeErr", 33'(modeErr), 33'h0);
    // Every length and order: a read, then a masked write
    for (int lc = 1; lc < 4; lc++) begin
      for (int t = 0; t < 2; t++) begin
        ctl.issue(C_PRE, 1'b0, 13'h0400, 4);
        ctl.issue(C_LOAD, 1'b0, {9'h2, 1'(t), 3'(lc)}, 4);
        ctl.issue(C_ACT, 1'b0, rnd[12:0], 4);
        rnd = lfsr(rnd);
        ctl.mask(rnd[31:30]);
        push(rnd[9:0], 1 << lc, t, 1'b0, 2'h0);
        ctl.issue(C_RD, 1'b0, {3'h0, rnd[9:0]}, 12);
        push(rnd[25:16], 1 << lc, t, 1'b1, ~rnd[31:30]);
        ctl.issue(C_WR, 1'b0, {3'h0, rnd[25:16]}, 12);
      end
    end
    // Active power-down with a bank open, then exit with a no-op
    ctl.doze(1'b1);
    repeat (8) @(posedge core_clk);
    check("powerDown", 33'(powerDown), 33'h1);
    apb(1'b0, 8'h0C, '0, 33'h071);
    ctl.doze(1'b0);
    repeat (8) @(posedge core_clk);
    check("powerDown", 33'(powerDown), 33'h0);
    check("beats left", 33'(beatQ.size()), 33'h0);
    report_and_stop();
  end

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    report_and_stop();
  end
endmodule : dmr_mode_ctl_test
`default_nettype wire
